// File: rtl/lathr_bank.sv
// Alarm threshold register bank with range checks and alarm compares
`include "lathr_regs.svh"

// Notes on behaviour
// - Fatal and warning power limits, 16-bit unsigned, hundredths of dB.
// - Power limit above usable range is rejected with execution error.
// - Success returns OK status and OK condition; writes echo, power and coarse writes act at once.
// - Failure returns execution error, zero data, applicable error condition.
// - Limits load saved defaults; saving configuration replaces the defaults.
// - Frequency limits split into coarse tenths-GHz and fine MHz registers.
// - Frequency limit equals coarse times 0.1 GHz plus fine times 1 MHz.
// - Out-of-range frequency limit raises execution error, value error code.
// - Combined frequency checked and committed only on coarse write.
// - Fine writes checked at once; values above 99 rejected.
// - Fine registers reset to zero; coarse defaults are parameters.
// - Fatal limits drive fatal alarm, warning limits drive warning alarm.
// - Power fault bits follow power deviation beyond each limit.
// - Frequency fault bits follow frequency deviation beyond each limit.
module lathr_bank #(
  parameter logic [15:0] POW_LIMIT_MAX = 16'h1388,
  parameter logic [23:0] FREQ_LIMIT_MAX = 24'h00c350,
  parameter logic [15:0] POW_FATAL_DEF = 16'h012c,
  parameter logic [15:0] POW_WARN_DEF = 16'h0064,
  parameter logic [15:0] FRQ_FATAL_COARSE_DEF = 16'h0014,
  parameter logic [15:0] FRQ_WARN_COARSE_DEF = 16'h000a
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [15:0] req_data_i,
  input wire logic save_config_i,
  input wire logic load_defaults_i,
  input wire logic signed [15:0] power_dev_i,
  input wire logic signed [23:0] freq_dev_i,
  output logic rsp_valid_o,
  output lathr_pkg::lathr_status_t rsp_status_o,
  output lathr_pkg::lathr_err_t rsp_error_o,
  output logic [15:0] rsp_data_o,
  output lathr_pkg::lathr_err_t no_operation_status_reg_o,
  output logic power_fatal_current_bit_o,
  output logic power_warning_current_bit_o,
  output logic freq_fatal_current_bit_o,
  output logic freq_warning_current_bit_o
);
  import lathr_pkg::*;

  // -------------------------------------------------------------------
  // Combined limit in MHz from coarse and fine parts
  // -------------------------------------------------------------------
  function automatic logic [23:0] lathr_combine(input logic [15:0] coarse,
                                                input logic [15:0] fine);
    logic [23:0] prod;
    prod = {8'h00, coarse} * `LATHR_MHZ_PER_COARSE;
    return prod + {8'h00, fine};
  endfunction : lathr_combine

  // Reset images of the committed MHz limits, fine parts zero
  localparam logic [23:0] FRQ_FATAL_MHZ_DEF =
    24'(FRQ_FATAL_COARSE_DEF) * `LATHR_MHZ_PER_COARSE;
  localparam logic [23:0] FRQ_WARN_MHZ_DEF =
    24'(FRQ_WARN_COARSE_DEF) * `LATHR_MHZ_PER_COARSE;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  // 16-bit power limits
  logic [15:0] power_fatal_limit;
  logic [15:0] power_warning_limit;
  logic [15:0] freq_fatal_limit_coarse;
  logic [15:0] freq_warning_limit_coarse;
  logic [15:0] freq_fatal_limit_fine;
  logic [15:0] freq_warning_limit_fine;
  logic [15:0] frq_fatal_fine_used;
  logic [15:0] frq_warn_fine_used;
  logic [23:0] frq_fatal_mhz;
  logic [23:0] frq_warn_mhz;
  logic [15:0] next_power_fatal_limit;
  logic [15:0] next_power_warning_limit;
  logic [15:0] next_freq_fatal_limit_coarse;
  logic [15:0] next_freq_warning_limit_coarse;
  logic [15:0] next_freq_fatal_limit_fine;
  logic [15:0] next_freq_warning_limit_fine;
  logic [15:0] next_frq_fatal_fine_used;
  logic [15:0] next_frq_warn_fine_used;
  logic [23:0] next_frq_fatal_mhz;
  logic [23:0] next_frq_warn_mhz;
  logic next_rsp_valid;
  lathr_status_t next_rsp_status;
  lathr_err_t next_rsp_error;
  logic [15:0] next_rsp_data;
  lathr_err_t next_nop;
  lathr_err_t err;
  logic [23:0] cand;
  logic [15:0] rdata;

  // Saved default images
  logic [15:0] sv_pow_fatal;
  logic [15:0] sv_pow_warn;
  logic [15:0] sv_frq_fatal_coarse;
  logic [15:0] sv_frq_warn_coarse;
  logic [15:0] sv_frq_fatal_fine;
  logic [15:0] sv_frq_warn_fine;
  logic [15:0] next_sv_pow_fatal;
  logic [15:0] next_sv_pow_warn;
  logic [15:0] next_sv_frq_fatal_coarse;
  logic [15:0] next_sv_frq_warn_coarse;
  logic [15:0] next_sv_frq_fatal_fine;
  logic [15:0] next_sv_frq_warn_fine;

  // -------------------------------------------------------------------
  // Command decode, range checks and response
  // -------------------------------------------------------------------
  always_comb begin
    next_power_fatal_limit = power_fatal_limit;
    next_power_warning_limit = power_warning_limit;
    next_freq_fatal_limit_coarse = freq_fatal_limit_coarse;
    next_freq_warning_limit_coarse = freq_warning_limit_coarse;
    next_freq_fatal_limit_fine = freq_fatal_limit_fine;
    next_freq_warning_limit_fine = freq_warning_limit_fine;
    next_frq_fatal_fine_used = frq_fatal_fine_used;
    next_frq_warn_fine_used = frq_warn_fine_used;
    next_frq_fatal_mhz = frq_fatal_mhz;
    next_frq_warn_mhz = frq_warn_mhz;
    next_rsp_valid = 1'b0;
    next_rsp_status = LATHR_ST_OK;
    next_rsp_error = LATHR_ERR_OK;
    next_rsp_data = `LATHR_DATA_ZERO;
    next_nop = no_operation_status_reg_o;
    err = LATHR_ERR_OK;
    cand = 24'h000000;
    rdata = `LATHR_DATA_ZERO;

    // restore saved defaults as one committed set
    if (load_defaults_i) begin
      next_power_fatal_limit = sv_pow_fatal;
      next_power_warning_limit = sv_pow_warn;
      next_freq_fatal_limit_coarse = sv_frq_fatal_coarse;
      next_freq_warning_limit_coarse = sv_frq_warn_coarse;
      next_freq_fatal_limit_fine = sv_frq_fatal_fine;
      next_freq_warning_limit_fine = sv_frq_warn_fine;
      next_frq_fatal_fine_used = sv_frq_fatal_fine;
      next_frq_warn_fine_used = sv_frq_warn_fine;
      next_frq_fatal_mhz = lathr_combine(sv_frq_fatal_coarse,
                                         sv_frq_fatal_fine);
      next_frq_warn_mhz = lathr_combine(sv_frq_warn_coarse,
                                        sv_frq_warn_fine);
    end

    if (req_valid_i) begin
      next_rsp_valid = 1'b1;
      if (load_defaults_i) begin
        // Reload owns the bank this cycle, so the command is refused
        err = LATHR_ERR_CIP;
      end else if (req_write_i) begin
        case (req_addr_i)
          `LATHR_OFS_POW_FATAL: begin
            if (req_data_i > POW_LIMIT_MAX) begin
              err = LATHR_ERR_RVE;
            end else begin
              next_power_fatal_limit = req_data_i;
            end
          end
          `LATHR_OFS_POW_WARN: begin
            if (req_data_i > POW_LIMIT_MAX) begin
              err = LATHR_ERR_RVE;
            end else begin
              next_power_warning_limit = req_data_i;
            end
          end
          `LATHR_OFS_FRQ_FATAL_COARSE: begin
            cand = lathr_combine(req_data_i, freq_fatal_limit_fine);
            if (cand > FREQ_LIMIT_MAX) begin
              err = LATHR_ERR_RVE;
            end else begin
              next_freq_fatal_limit_coarse = req_data_i;
              next_frq_fatal_fine_used = freq_fatal_limit_fine;
              next_frq_fatal_mhz = cand;
            end
          end
          `LATHR_OFS_FRQ_WARN_COARSE: begin
            cand = lathr_combine(req_data_i, freq_warning_limit_fine);
            if (cand > FREQ_LIMIT_MAX) begin
              err = LATHR_ERR_RVE;
            end else begin
              next_freq_warning_limit_coarse = req_data_i;
              next_frq_warn_fine_used = freq_warning_limit_fine;
              next_frq_warn_mhz = cand;
            end
          end
          `LATHR_OFS_FRQ_FATAL_FINE: begin
            if (req_data_i > `LATHR_FINE_MAX) begin
              err = LATHR_ERR_RVE;
            end else begin
              next_freq_fatal_limit_fine = req_data_i;
            end
          end
          `LATHR_OFS_FRQ_WARN_FINE: begin
            if (req_data_i > `LATHR_FINE_MAX) begin
              err = LATHR_ERR_RVE;
            end else begin
              next_freq_warning_limit_fine = req_data_i;
            end
          end
          default: begin
            err = LATHR_ERR_CII;
          end
        endcase
        rdata = req_data_i;
      end else begin
        // Fine reads return the staged value, committed or not
        case (req_addr_i)
          `LATHR_OFS_POW_FATAL: rdata = power_fatal_limit;
          `LATHR_OFS_POW_WARN: rdata = power_warning_limit;
          `LATHR_OFS_FRQ_FATAL_COARSE: rdata = freq_fatal_limit_coarse;
          `LATHR_OFS_FRQ_WARN_COARSE: rdata = freq_warning_limit_coarse;
          `LATHR_OFS_FRQ_FATAL_FINE: rdata = freq_fatal_limit_fine;
          `LATHR_OFS_FRQ_WARN_FINE: rdata = freq_warning_limit_fine;
          default: begin
            err = LATHR_ERR_CII;
          end
        endcase
      end

      if (err == LATHR_ERR_OK) begin
        next_rsp_data = rdata;
      end else begin
        next_rsp_status = LATHR_ST_XE;
        next_rsp_data = `LATHR_DATA_ZERO;
      end
      next_rsp_error = err;
      next_nop = err;
    end
  end

  // Limits, response and no-operation status
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_fatal_limit <= POW_FATAL_DEF;
      power_warning_limit <= POW_WARN_DEF;
      freq_fatal_limit_coarse <= FRQ_FATAL_COARSE_DEF;
      freq_warning_limit_coarse <= FRQ_WARN_COARSE_DEF;
      freq_fatal_limit_fine <= `LATHR_FINE_RST;
      freq_warning_limit_fine <= `LATHR_FINE_RST;
      frq_fatal_fine_used <= `LATHR_FINE_RST;
      frq_warn_fine_used <= `LATHR_FINE_RST;
      frq_fatal_mhz <= FRQ_FATAL_MHZ_DEF;
      frq_warn_mhz <= FRQ_WARN_MHZ_DEF;
      rsp_valid_o <= 1'b0;
      rsp_status_o <= LATHR_ST_OK;
      rsp_error_o <= LATHR_ERR_OK;
      rsp_data_o <= `LATHR_DATA_ZERO;
      no_operation_status_reg_o <= LATHR_ERR_OK;
    end else begin
      power_fatal_limit <= next_power_fatal_limit;
      power_warning_limit <= next_power_warning_limit;
      freq_fatal_limit_coarse <= next_freq_fatal_limit_coarse;
      freq_warning_limit_coarse <= next_freq_warning_limit_coarse;
      freq_fatal_limit_fine <= next_freq_fatal_limit_fine;
      freq_warning_limit_fine <= next_freq_warning_limit_fine;
      frq_fatal_fine_used <= next_frq_fatal_fine_used;
      frq_warn_fine_used <= next_frq_warn_fine_used;
      frq_fatal_mhz <= next_frq_fatal_mhz;
      frq_warn_mhz <= next_frq_warn_mhz;
      rsp_valid_o <= next_rsp_valid;
      rsp_status_o <= next_rsp_status;
      rsp_error_o <= next_rsp_error;
      rsp_data_o <= next_rsp_data;
      no_operation_status_reg_o <= next_nop;
    end
  end

  // -------------------------------------------------------------------
  // Saved defaults, standing in for non-volatile storage
  // -------------------------------------------------------------------
  // save captures the committed set, never a half-done fine edit
  always_comb begin
    next_sv_pow_fatal = sv_pow_fatal;
    next_sv_pow_warn = sv_pow_warn;
    next_sv_frq_fatal_coarse = sv_frq_fatal_coarse;
    next_sv_frq_warn_coarse = sv_frq_warn_coarse;
    next_sv_frq_fatal_fine = sv_frq_fatal_fine;
    next_sv_frq_warn_fine = sv_frq_warn_fine;
    if (save_config_i) begin
      next_sv_pow_fatal = power_fatal_limit;
      next_sv_pow_warn = power_warning_limit;
      next_sv_frq_fatal_coarse = freq_fatal_limit_coarse;
      next_sv_frq_warn_coarse = freq_warning_limit_coarse;
      next_sv_frq_fatal_fine = frq_fatal_fine_used;
      next_sv_frq_warn_fine = frq_warn_fine_used;
    end
  end

  // Saved images reset to the build-time defaults
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sv_pow_fatal <= POW_FATAL_DEF;
      sv_pow_warn <= POW_WARN_DEF;
      sv_frq_fatal_coarse <= FRQ_FATAL_COARSE_DEF;
      sv_frq_warn_coarse <= FRQ_WARN_COARSE_DEF;
      sv_frq_fatal_fine <= `LATHR_FINE_RST;
      sv_frq_warn_fine <= `LATHR_FINE_RST;
    end else begin
      sv_pow_fatal <= next_sv_pow_fatal;
      sv_pow_warn <= next_sv_pow_warn;
      sv_frq_fatal_coarse <= next_sv_frq_fatal_coarse;
      sv_frq_warn_coarse <= next_sv_frq_warn_coarse;
      sv_frq_fatal_fine <= next_sv_frq_fatal_fine;
      sv_frq_warn_fine <= next_sv_frq_warn_fine;
    end
  end

  // -------------------------------------------------------------------
  // Alarm compares against committed limits
  // -------------------------------------------------------------------
  // fatal and warning limits feed their own alarms
  lathr_cmp #(
    .W(16)
  ) u_pow_fatal (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .dev_i(power_dev_i),
    .limit_i(power_fatal_limit),
    .exceed_o(power_fatal_current_bit_o)
  );

  lathr_cmp #(
    .W(16)
  ) u_pow_warn (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .dev_i(power_dev_i),
    .limit_i(power_warning_limit),
    .exceed_o(power_warning_current_bit_o)
  );

  lathr_cmp #(
    .W(24)
  ) u_frq_fatal (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .dev_i(freq_dev_i),
    .limit_i(frq_fatal_mhz),
    .exceed_o(freq_fatal_current_bit_o)
  );

  lathr_cmp #(
    .W(24)
  ) u_frq_warn (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .dev_i(freq_dev_i),
    .limit_i(frq_warn_mhz),
    .exceed_o(freq_warning_current_bit_o)
  );

endmodule : lathr_bank

// File: rtl/lathr_regs.svh
// Offsets, field limits and reset values of the alarm threshold bank
`ifndef LATHR_REGS_SVH
`define LATHR_REGS_SVH

// ---------------------------------------------------------------------
// Register numbers
// ---------------------------------------------------------------------
`define LATHR_OFS_POW_FATAL 8'h22
`define LATHR_OFS_POW_WARN 8'h23
`define LATHR_OFS_FRQ_FATAL_COARSE 8'h24
`define LATHR_OFS_FRQ_WARN_COARSE 8'h25
`define LATHR_OFS_FRQ_FATAL_FINE 8'h63
`define LATHR_OFS_FRQ_WARN_FINE 8'h64

// ---------------------------------------------------------------------
// Field limits and scaling
// ---------------------------------------------------------------------
// Highest legal fine value, in MHz
`define LATHR_FINE_MAX 16'h0063
// MHz carried by one coarse step of a tenth of a GHz
`define LATHR_MHZ_PER_COARSE 24'h000064

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define LATHR_FINE_RST 16'h0000
`define LATHR_DATA_ZERO 16'h0000

`endif

// File: rtl/lathr_pkg.sv
// Types shared by the alarm threshold bank
package lathr_pkg;

  // -------------------------------------------------------------------
  // Status field of a response
  // -------------------------------------------------------------------
  typedef enum logic [0:0] {
    LATHR_ST_OK = 1'b0,
    LATHR_ST_XE = 1'b1
  } lathr_status_t;

  // -------------------------------------------------------------------
  // Error condition field, also kept as the no-operation status
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    LATHR_ERR_OK = 4'h0,
    LATHR_ERR_RNW = 4'h1,
    LATHR_ERR_RVE = 4'h2,
    LATHR_ERR_CIP = 4'h3,
    LATHR_ERR_CII = 4'h4,
    LATHR_ERR_EXF = 4'h5,
    LATHR_ERR_VSE = 4'h6
  } lathr_err_t;

endpackage : lathr_pkg

// File: rtl/lathr_cmp.sv
// Magnitude comparator that flags a deviation beyond a limit
module lathr_cmp #(
  parameter int W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic signed [W-1:0] dev_i,
  input wire logic [W-1:0] limit_i,
  output logic exceed_o
);

  logic [W-1:0] magnitude;
  logic next_exceed;

  // Absolute value; the most negative code maps to 2**(W-1) unsigned
  always_comb begin
    magnitude = dev_i[W-1] ? W'(-dev_i) : W'(dev_i);
    next_exceed = magnitude > limit_i;
  end

  // Registered so the alarm bit comes straight from a flop
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      exceed_o <= 1'b0;
    end else begin
      exceed_o <= next_exceed;
    end
  end

endmodule : lathr_cmp

// File: testbench/lathr_bank_asserts.sv
// Checker of the threshold bank command port and power fatal alarm bit
module lathr_bank_asserts #(
  parameter logic [15:0] POW_LIMIT_MAX = 16'h1388
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [15:0] req_data_i,
  input wire logic load_defaults_i,
  input wire logic signed [15:0] power_dev_i,
  input wire logic rsp_valid_o,
  input lathr_pkg::lathr_status_t rsp_status_o,
  input lathr_pkg::lathr_err_t rsp_error_o,
  input wire logic [15:0] rsp_data_o,
  input lathr_pkg::lathr_err_t no_operation_status_reg_o,
  input wire logic power_fatal_current_bit_o
);
  import lathr_pkg::*;
  // ---------------------------------------------------------------
  // Decoded command kinds
  // ---------------------------------------------------------------
  logic mapped;
  logic pw_wr;
  logic fn_wr;
  assign mapped = req_addr_i inside {8'h22, 8'h23, 8'h24, 8'h25, 8'h63,
    8'h64};
  assign pw_wr = req_valid_i && req_write_i && !load_defaults_i &&
    req_addr_i inside {8'h22, 8'h23};
  assign fn_wr = req_valid_i && req_write_i && !load_defaults_i &&
    req_addr_i inside {8'h63, 8'h64};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Response timing and fields
  rsp_follows_a: assert property (req_valid_i |=> rsp_valid_o)
    else $error("response missing");
  rsp_unasked_a: assert property (!req_valid_i |=> !rsp_valid_o)
    else $error("response without command");
  ok_cond_a: assert property (rsp_valid_o && rsp_status_o == LATHR_ST_OK
    |-> rsp_error_o == LATHR_ERR_OK) else $error("ok with error code");
  err_zero_data_a: assert property (rsp_valid_o &&
    rsp_status_o == LATHR_ST_XE |-> rsp_data_o == 16'h0000 &&
    rsp_error_o != LATHR_ERR_OK) else $error("error data not zero");
  unmapped_cii_a: assert property (req_valid_i && !mapped &&
    !load_defaults_i |=> rsp_status_o == LATHR_ST_XE &&
    rsp_error_o == LATHR_ERR_CII) else $error("unmapped not refused");
  busy_cip_a: assert property (req_valid_i && load_defaults_i
    |=> rsp_error_o == LATHR_ERR_CIP) else $error("load clash missed");
  // Range checks and echo
  pow_range_a: assert property (pw_wr && req_data_i > POW_LIMIT_MAX
    |=> rsp_error_o == LATHR_ERR_RVE) else $error("power range missed");
  pow_echo_a: assert property (pw_wr && req_data_i <= POW_LIMIT_MAX
    |=> rsp_status_o == LATHR_ST_OK && rsp_data_o == $past(req_data_i))
    else $error("power echo wrong");
  fine_range_a: assert property (fn_wr |=> (rsp_error_o ==
    LATHR_ERR_RVE) == ($past(req_data_i) > 16'h0063))
    else $error("fine range wrong");
  nop_match_a: assert property (rsp_valid_o |->
    no_operation_status_reg_o == rsp_error_o) else $error("nop differs");
  zero_dev_a: assert property (power_dev_i == 16'sh0000
    |=> !power_fatal_current_bit_o) else $error("alarm at zero");
  cover property (pw_wr ##1 rsp_status_o == LATHR_ST_OK);
  cover property (fn_wr ##1 rsp_error_o == LATHR_ERR_RVE);
  cover property (req_valid_i && load_defaults_i);
  cover property (power_fatal_current_bit_o);
endmodule : lathr_bank_asserts

bind lathr_bank lathr_bank_asserts #(.POW_LIMIT_MAX(POW_LIMIT_MAX))
  lathr_bank_asserts_i (.core_clk_i, .rst_i, .req_valid_i, .req_write_i,
  .req_addr_i, .req_data_i, .load_defaults_i, .power_dev_i, .rsp_valid_o,
  .rsp_status_o, .rsp_error_o, .rsp_data_o, .no_operation_status_reg_o,
  .power_fatal_current_bit_o);

// File: testbench/lathr_host.sv
// Host model issuing register commands to the threshold bank
module lathr_host (
  input wire logic core_clk_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [7:0] req_addr_o,
  output logic [15:0] req_data_o,
  input wire logic rsp_valid_i,
  input lathr_pkg::lathr_status_t rsp_status_i,
  input lathr_pkg::lathr_err_t rsp_error_i,
  input wire logic [15:0] rsp_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import lathr_pkg::*;
  lathr_status_t st;
  lathr_err_t er;
  logic [15:0] dt;
  logic got;
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_addr_o = 8'h00;
    req_data_o = 16'h0000;
  end
  // ---------------------------------------------------------------
  // One command; idle lines show the inverse so stale values fail
  // ---------------------------------------------------------------
  task automatic cmd(input logic w, input logic [7:0] a,
      input logic [15:0] d);
    @(negedge core_clk_i);
    req_valid_o = 1'b1;
    req_write_o = w;
    req_addr_o = a;
    req_data_o = d;
    // Response strobe stands only one cycle, so read it mid-cycle
    @(negedge core_clk_i);
    got = rsp_valid_i;
    st = rsp_status_i;
    er = rsp_error_i;
    dt = rsp_data_i;
    req_valid_o = 1'b0;
    req_write_o = ~w;
    req_addr_o = ~a;
    req_data_o = ~d;
  endtask : cmd
endmodule : lathr_host

// File: testbench/lathr_bank_bench.sv
// Self-checking bench of the alarm threshold bank
module lathr_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lathr_pkg::*;
  localparam logic [15:0] PMAX = 16'h1388;
  localparam logic [23:0] FMAX = 24'h00c350;
  logic core_clk, rst, req_valid, req_write, save_cfg, load_def;
  logic [7:0] req_addr;
  logic [15:0] req_data, rsp_data;
  logic signed [15:0] pdev;
  logic signed [23:0] fdev;
  logic rsp_valid, pf_bit, pw_bit, ff_bit, fw_bit;
  lathr_status_t rsp_status;
  lathr_err_t rsp_error, nop_reg;
  int bad_count, num_checks;
  // Expected registers: power fatal, warn, coarse pair, fine pair
  int lim [6];
  // Committed frequency limits in MHz, fatal then warning
  int com [2];
  logic [7:0] addrs [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h63, 8'h64,
    8'h26};
  logic [15:0] picks [6] = '{16'h1388, 16'h1389, 16'h0063, 16'h0064,
    16'h01f4, 16'h01f5};

  lathr_bank #(.POW_LIMIT_MAX(PMAX), .FREQ_LIMIT_MAX(FMAX)) lathr_bank_i (
    .core_clk_i(core_clk),
    .rst_i(rst),
    .req_valid_i(req_valid),
    .req_write_i(req_write),
    .req_addr_i(req_addr),
    .req_data_i(req_data),
    .save_config_i(save_cfg),
    .load_defaults_i(load_def),
    .power_dev_i(pdev),
    .freq_dev_i(fdev),
    .rsp_valid_o(rsp_valid),
    .rsp_status_o(rsp_status),
    .rsp_error_o(rsp_error),
    .rsp_data_o(rsp_data),
    .no_operation_status_reg_o(nop_reg),
    .power_fatal_current_bit_o(pf_bit),
    .power_warning_current_bit_o(pw_bit),
    .freq_fatal_current_bit_o(ff_bit),
    .freq_warning_current_bit_o(fw_bit)
  );

  lathr_host lathr_host_i (
    .core_clk_i(core_clk),
    .req_valid_o(req_valid),
    .req_write_o(req_write),
    .req_addr_o(req_addr),
    .req_data_o(req_data),
    .rsp_valid_i(rsp_valid),
    .rsp_status_i(rsp_status),
    .rsp_error_i(rsp_error),
    .rsp_data_i(rsp_data)
  );

  // ---------------------------------------------------------------
  // Expectation and checking helpers
  // ---------------------------------------------------------------
  function automatic void expect_cmd(input logic w, input logic [7:0] a,
      input int d, output lathr_status_t s, output lathr_err_t e,
      output int v);
    int i;
    i = -1;
    for (int k = 0; k < 6; k++) if (addrs[k] == a) i = k;
    s = LATHR_ST_XE;
    e = LATHR_ERR_CII;
    v = 0;
    if (i < 0) return;
    e = LATHR_ERR_RVE;
    if (!w) v = lim[i];
    else if (i < 2 && d > PMAX) return;
    else if (i > 3 && d > 99) return;
    else if (i inside {2, 3} && d * 100 + lim[i + 2] > FMAX) return;
    else begin
      // Only a coarse write moves the committed limit
      lim[i] = d;
      v = d;
      if (i inside {2, 3}) com[i - 2] = d * 100 + lim[i + 2];
    end
    s = LATHR_ST_OK;
    e = LATHR_ERR_OK;
  endfunction : expect_cmd

  task automatic check(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : check

  task automatic run(input logic w, input logic [7:0] a,
      input logic [15:0] d);
    lathr_status_t s;
    lathr_err_t e;
    int v;
    expect_cmd(w, a, d, s, e, v);
    lathr_host_i.cmd(w, a, d);
    check(lathr_host_i.got === 1'b1 && lathr_host_i.st === s &&
      lathr_host_i.er === e && lathr_host_i.dt === v[15:0] &&
      nop_reg === e, "response mismatch");
  endtask : run

  // Deviation at, just under or just over a limit, either sign
  task automatic alarms();
    int pd;
    int fd;
    pd = lim[$urandom % 2] + int'($urandom % 3) - 1;
    fd = com[$urandom % 2] + int'($urandom % 3) - 1;
    pd = pd < 0 ? -pd : pd;
    fd = fd < 0 ? -fd : fd;
    @(negedge core_clk);
    pdev = $urandom % 2 ? 16'(-pd) : 16'(pd);
    fdev = $urandom % 2 ? 24'(-fd) : 24'(fd);
    @(posedge core_clk);
    @(negedge core_clk);
    check(pf_bit === (pd > lim[0]) && pw_bit === (pd > lim[1]), "power");
    check(ff_bit === (fd > com[0]) && fw_bit === (fd > com[1]), "freq");
  endtask : alarms

  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    save_cfg = 1'b0;
    load_def = 1'b0;
    pdev = 16'sh0000;
    fdev = 24'sh000000;
    bad_count = 0;
    num_checks = 0;
    lim = '{300, 100, 20, 10, 0, 0};
    com = '{2000, 1000};
    void'($urandom(32'h557f));
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) run(1'b0, addrs[i], 16'h0000);
    run(1'b1, 8'h63, 16'd75); // fine part first
    run(1'b1, 8'h24, 16'd56);
    run(1'b1, 8'h23, 16'd250); // warning at or below fatal
    run(1'b1, 8'h25, 16'd15); // warning below fatal
    alarms();
    run(1'b1, 8'h63, 16'd0); // staged only
    alarms();
    repeat (300) begin
      run(1'($urandom % 2), addrs[$urandom % 7], $urandom % 3 == 0 ?
        16'($urandom) : ($urandom % 2 ? picks[$urandom % 6] :
        16'($urandom % 600)));
      alarms();
    end
    // Saved image survives later writes and comes back on load
    run(1'b1, 8'h22, 16'd1234);
    @(negedge core_clk);
    save_cfg = 1'b1;
    @(negedge core_clk);
    save_cfg = 1'b0;
    run(1'b1, 8'h22, 16'd4321);
    fork
      lathr_host_i.cmd(1'b1, 8'h22, 16'd77);
      begin
        @(negedge core_clk);
        load_def = 1'b1;
        @(negedge core_clk);
        load_def = 1'b0;
      end
    join
    check(lathr_host_i.st === LATHR_ST_XE &&
      lathr_host_i.er === LATHR_ERR_CIP, "clash");
    lim[0] = 1234;
    run(1'b0, 8'h22, 16'h0000);
    alarms();
    finish_test();
  end
endmodule : lathr_bank_bench
